// File: verilog/pics_pkg.sv
// Constants for the PHY interrupt control and status block
package pics_pkg;
  localparam int          PICS_EVENTS       = 8;
  localparam int          PICS_ADDR_W       = 8;
  localparam logic [7:0]  PICS_REG_INDEX    = 8'h1B;
  localparam logic [9:0]  PICS_REG_BYTE_W   = {2'h0, PICS_REG_INDEX} << 2;
  localparam logic [7:0]  PICS_REG_ADDR     = PICS_REG_BYTE_W[7:0];
  localparam int          PICS_EN_LSB       = 8;
  localparam int          PICS_FLAG_LSB     = 0;
  localparam int          PICS_EN_BYTE      = 1;
  localparam logic [7:0]  PICS_EN_RESET     = 8'h00;
  localparam logic [7:0]  PICS_FLAG_RESET   = 8'h00;
  localparam logic [31:0] PICS_RDATA_RESET  = 32'h0000_0000;
  localparam logic [7:0]  PICS_ZERO_BYTE    = 8'h00;
  localparam logic [15:0] PICS_ZERO_UPPER   = 16'h0000;
  localparam int          PICS_EV_JABBER    = 7;
  localparam int          PICS_EV_RXERR     = 6;
  localparam int          PICS_EV_PAGE      = 5;
  localparam int          PICS_EV_PDFAULT   = 4;
  localparam int          PICS_EV_LPACK     = 3;
  localparam int          PICS_EV_LINKDOWN  = 2;
  localparam int          PICS_EV_REMFAULT  = 1;
  localparam int          PICS_EV_LINKUP    = 0;
  typedef enum logic [0:0] {
    PICS_ST_IDLE = 1'b0,
    PICS_ST_ACK  = 1'b1
  } pics_state_t;
endpackage : pics_pkg

// File: verilog/pics_interrupt_control.sv
// PHY interrupt control and status register with Avalon-MM slave
//
// How it works
// - Bit 15 enables jabber interrupts; read/write, resets to zero.
// - Bit 14 enables receive error interrupts; read/write, resets to zero.
// - Bit 13 enables page received interrupts; read/write, resets to zero.
// - Bit 12 enables parallel detect fault interrupts; read/write, resets to zero.
// - Bit 11 enables link partner acknowledge interrupts; read/write, resets zero.
// - Bit 10 enables link-down interrupts; read/write, resets to zero.
// - Bit 9 enables remote fault interrupts; read/write, resets to zero.
// - Bit 8 enables link-up interrupts; read/write, resets to zero.
// - Bit 7 is a read-only sticky flag for jabber, cleared by reading.
// - Bit 6 is a read-only sticky flag for receive error, cleared by reading.
// - Bit 5 is a read-only sticky flag for page received, cleared by reading.
// - Bit 4 is a read-only sticky flag for parallel detect fault.
// - Bit 3 is a read-only sticky flag for link partner acknowledge.
// - Bit 2 is a read-only sticky flag for link-down.
// - Bit 1 is a read-only sticky flag for remote fault.
// - Bit 0 is a read-only sticky flag for link-up.
`timescale 1ns/1ps
`default_nettype none
module pics_interrupt_control
  import pics_pkg::*;
(
  input  wire logic                   mclk,
  input  wire logic                   arst_n,
  input  wire logic [PICS_ADDR_W-1:0] avs_address,
  input  wire logic                   avs_read,
  input  wire logic                   avs_write,
  input  wire logic [31:0]            avs_writedata,
  input  wire logic [3:0]             avs_byteenable,
  output var  logic [31:0]            avs_readdata,
  output var  logic                   avs_waitrequest,
  input  wire logic                   linkClk,
  input  wire logic                   evJabber,
  input  wire logic                   evRxError,
  input  wire logic                   evPageRx,
  input  wire logic                   evParDetFault,
  input  wire logic                   evLpAck,
  input  wire logic                   evLinkDown,
  input  wire logic                   evRemoteFault,
  input  wire logic                   evLinkUp,
  output var  logic                   irq
);

  logic [PICS_EVENTS-1:0] evPins;
  logic [PICS_EVENTS-1:0] evMeta_reg;
  logic [PICS_EVENTS-1:0] evSync_reg;
  logic                   clkMeta_reg;
  logic                   clkSync_reg;
  logic                   clkPrev_reg;
  logic                   linkRise;
  logic [PICS_EVENTS-1:0] evSet;
  logic [PICS_EVENTS-1:0] enable_reg;
  logic [PICS_EVENTS-1:0] flags_reg;
  logic [PICS_EVENTS-1:0] flags_next;
  logic [PICS_EVENTS-1:0] snap_reg;
  pics_state_t            state_reg;
  pics_state_t            state_next;
  logic                   request;
  logic                   hitReg;
  logic                   accept;
  logic                   acceptWr;
  logic                   acceptRd;
  logic                   irq_next;

  assign evPins[PICS_EV_JABBER]   = evJabber;
  assign evPins[PICS_EV_RXERR]    = evRxError;
  assign evPins[PICS_EV_PAGE]     = evPageRx;
  assign evPins[PICS_EV_PDFAULT]  = evParDetFault;
  assign evPins[PICS_EV_LPACK]    = evLpAck;
  assign evPins[PICS_EV_LINKDOWN] = evLinkDown;
  assign evPins[PICS_EV_REMFAULT] = evRemoteFault;
  assign evPins[PICS_EV_LINKUP]   = evLinkUp;

  // Two-stage synchronisers for link clock and events
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      evMeta_reg  <= PICS_FLAG_RESET;
      evSync_reg  <= PICS_FLAG_RESET;
      clkMeta_reg <= 1'b0;
      clkSync_reg <= 1'b0;
      clkPrev_reg <= 1'b0;
    end else begin
      evMeta_reg  <= evPins;
      evSync_reg  <= evMeta_reg;
      clkMeta_reg <= linkClk;
      clkSync_reg <= clkMeta_reg;
      clkPrev_reg <= clkSync_reg;
    end
  end

  assign linkRise = clkSync_reg & ~clkPrev_reg;

  // Bus handshake
  assign request  = avs_read | avs_write;
  assign hitReg   = (avs_address == PICS_REG_ADDR);
  assign accept   = request & (state_reg == PICS_ST_ACK);
  assign acceptWr = accept & avs_write;
  assign acceptRd = accept & avs_read;
  assign avs_waitrequest = request & (state_reg != PICS_ST_ACK);

  always_comb begin
    case (state_reg)
      PICS_ST_IDLE: state_next = request ? PICS_ST_ACK : PICS_ST_IDLE;
      PICS_ST_ACK:  state_next = PICS_ST_IDLE;
      default:      state_next = PICS_ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= PICS_ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Read data captured one cycle before the answer
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      avs_readdata <= PICS_RDATA_RESET;
      snap_reg     <= PICS_FLAG_RESET;
    end else if (state_reg == PICS_ST_IDLE && avs_read) begin
      if (hitReg) begin
        avs_readdata <= {PICS_ZERO_UPPER, enable_reg, flags_reg};
        snap_reg     <= flags_reg;
      end else begin
        avs_readdata <= PICS_RDATA_RESET;
        snap_reg     <= PICS_FLAG_RESET;
      end
    end
  end

  // Enable bits, upper byte only
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      enable_reg <= PICS_EN_RESET;
    end else if (acceptWr && hitReg && avs_byteenable[PICS_EN_BYTE]) begin
      enable_reg <= avs_writedata[PICS_EN_LSB +: PICS_EVENTS];
    end
  end

  // Sticky event flags, set wins over clear
  genvar gi;
  generate
    for (gi = 0; gi < PICS_EVENTS; gi++) begin : g_flag
      assign evSet[gi] = linkRise & evSync_reg[gi];
      assign flags_next[gi] = evSet[gi] | (flags_reg[gi] & ~(acceptRd & snap_reg[gi]));
    end
  endgenerate

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      flags_reg <= PICS_FLAG_RESET;
    end else begin
      flags_reg <= flags_next;
    end
  end

  // Interrupt output
  assign irq_next = |(flags_reg & enable_reg);

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= irq_next;
    end
  end

  // Assertions
  sequence s_enWrite;
    acceptWr && hitReg && avs_byteenable[PICS_EN_BYTE];
  endsequence

  sequence s_readAccepted;
    acceptRd && hitReg;
  endsequence

  property p_enUpper;
    @(posedge mclk) disable iff (!arst_n)
      s_enWrite |=> enable_reg[7:4] == $past(avs_writedata[15:12]);
  endproperty

  property p_enLower;
    @(posedge mclk) disable iff (!arst_n)
      s_enWrite |=> enable_reg[3:0] == $past(avs_writedata[11:8]);
  endproperty

  a_en_upper_write: assert property (p_enUpper)
    else $error("Upper enable bits did not take written value");

  a_en_lower_write: assert property (p_enLower)
    else $error("Lower enable bits did not take written value");

  a_en_stable_hold: assert property (
    @(posedge mclk) disable iff (!arst_n)
      !(acceptWr && hitReg) |=> $stable(enable_reg))
    else $error("Enable bits changed without a write");

  a_flag_set_upper: assert property (
    @(posedge mclk) disable iff (!arst_n)
      (|evSet[7:4]) |=> ((flags_reg[7:4] & $past(evSet[7:4])) == $past(evSet[7:4])))
    else $error("Upper event flag not set by its event");

  a_flag_set_lower: assert property (
    @(posedge mclk) disable iff (!arst_n)
      (|evSet[3:0]) |=> ((flags_reg[3:0] & $past(evSet[3:0])) == $past(evSet[3:0])))
    else $error("Lower event flag not set by its event");

  a_flag_no_spont: assert property (
    @(posedge mclk) disable iff (!arst_n)
      ##1 ((flags_reg & ~$past(flags_reg)) & ~$past(evSet)) == PICS_FLAG_RESET)
    else $error("Event flag rose without an event");

  a_read_clears: assert property (
    @(posedge mclk) disable iff (!arst_n)
      s_readAccepted |=> ((flags_reg & $past(snap_reg) & ~$past(evSet)) == PICS_FLAG_RESET))
    else $error("Read did not clear reported flags");

  a_read_keeps: assert property (
    @(posedge mclk) disable iff (!arst_n)
      s_readAccepted |=> ((flags_reg & $past(evSet)) == $past(evSet)))
    else $error("Event during read was lost");

  a_irq_follows: assert property (
    @(posedge mclk) disable iff (!arst_n)
      ##1 irq == $past(|(flags_reg & enable_reg)))
    else $error("Interrupt output does not follow enabled flags");

  a_wait_bound: assert property (
    @(posedge mclk) disable iff (!arst_n)
      (request && state_reg == PICS_ST_IDLE) |=> !avs_waitrequest)
    else $error("Bus request not answered in one cycle");

  sequence s_reqIdle;
    request && state_reg == PICS_ST_IDLE;
  endsequence

  sequence s_readIdleHit;
    avs_read && state_reg == PICS_ST_IDLE && hitReg;
  endsequence

  sequence s_readIdleMiss;
    avs_read && state_reg == PICS_ST_IDLE && !hitReg;
  endsequence

  sequence s_enBlocked;
    acceptWr && !(hitReg && avs_byteenable[PICS_EN_BYTE]);
  endsequence

  property p_waitFirst;
    @(posedge mclk) disable iff (!arst_n)
      s_reqIdle |-> avs_waitrequest;
  endproperty

  a_wait_first_cycle: assert property (p_waitFirst)
    else $error("Waitrequest low on first request cycle");

  property p_ackOnce;
    @(posedge mclk) disable iff (!arst_n)
      state_reg == PICS_ST_ACK |=> state_reg == PICS_ST_IDLE;
  endproperty

  a_ack_one_cycle: assert property (p_ackOnce)
    else $error("Acknowledge state lasted more than one cycle");

  property p_idleNoWait;
    @(posedge mclk) disable iff (!arst_n)
      !request |-> !avs_waitrequest;
  endproperty

  a_wait_no_request: assert property (p_idleNoWait)
    else $error("Waitrequest high without a request");

  property p_rdEnables;
    @(posedge mclk) disable iff (!arst_n)
      s_readIdleHit |=> avs_readdata[15:8] == $past(enable_reg);
  endproperty

  a_rdata_enables: assert property (p_rdEnables)
    else $error("Read data does not show enable bits");

  property p_rdFlags;
    @(posedge mclk) disable iff (!arst_n)
      s_readIdleHit |=> avs_readdata[7:0] == $past(flags_reg);
  endproperty

  a_rdata_flags: assert property (p_rdFlags)
    else $error("Read data does not show event flags");

  property p_rdMiss;
    @(posedge mclk) disable iff (!arst_n)
      s_readIdleMiss |=> avs_readdata == PICS_RDATA_RESET;
  endproperty

  a_rdata_unmapped: assert property (p_rdMiss)
    else $error("Unmapped read returned nonzero data");

  property p_rdUpper;
    @(posedge mclk) disable iff (!arst_n)
      avs_readdata[31:16] == PICS_ZERO_UPPER;
  endproperty

  a_rdata_upper_zero: assert property (p_rdUpper)
    else $error("Upper read data bits not zero");

  property p_rdHold;
    @(posedge mclk) disable iff (!arst_n)
      !(avs_read && state_reg == PICS_ST_IDLE) |=> $stable(avs_readdata);
  endproperty

  a_rdata_hold: assert property (p_rdHold)
    else $error("Read data changed without a read");

  property p_enBlocked;
    @(posedge mclk) disable iff (!arst_n)
      s_enBlocked |=> $stable(enable_reg);
  endproperty

  a_en_write_blocked: assert property (p_enBlocked)
    else $error("Enable bits changed by an ignored write");

  property p_snapTaken;
    @(posedge mclk) disable iff (!arst_n)
      s_readIdleHit |=> snap_reg == $past(flags_reg);
  endproperty

  a_snap_taken: assert property (p_snapTaken)
    else $error("Read snapshot does not match flags");

  property p_flagSticky;
    @(posedge mclk) disable iff (!arst_n)
      ##1 ((~flags_reg & $past(flags_reg) & ~($past(snap_reg) & {PICS_EVENTS{$past(acceptRd)}})) == PICS_FLAG_RESET);
  endproperty

  a_flag_sticky: assert property (p_flagSticky)
    else $error("Event flag cleared without a read");

  property p_irqClear;
    @(posedge mclk) disable iff (!arst_n)
      (flags_reg & enable_reg) == PICS_FLAG_RESET |=> !irq;
  endproperty

  a_irq_clears: assert property (p_irqClear)
    else $error("Interrupt high with no enabled flag");

  property p_irqSet;
    @(posedge mclk) disable iff (!arst_n)
      (|(flags_reg & enable_reg)) |=> irq;
  endproperty

  a_irq_sets: assert property (p_irqSet)
    else $error("Interrupt low with an enabled flag");

endmodule : pics_interrupt_control
`default_nettype wire

// File: verif/pics_event_source.sv
// Event source model standing in for the PHY core side
`timescale 1ns/1ps
`default_nettype none
module pics_event_source (
  input  wire logic [7:0] evReq,
  output var  logic       linkClk,
  output var  logic [7:0] evLine
);
  initial begin
    evLine  = 8'h00;
    linkClk = 1'b0;
    forever #160 linkClk = ~linkClk;
  end
  // Events change on the falling edge, stable over a rise
  always @(negedge linkClk) evLine <= evReq;
endmodule : pics_event_source
`default_nettype wire

// File: verif/testbench.sv
// Register and event tests for the interrupt control block
`timescale 1ns/1ps
`default_nettype none
module testbench
  import pics_pkg::*;
;
  logic        mclk, arst_n, avsRead, avsWrite, irq, avsWait, linkClk;
  logic [7:0]  avsAddr, evReq, evLine;
  logic [31:0] avsWdata, avsRdata, rd;
  logic [3:0]  avsBe;
  logic [15:0] en;
  int          failCount, samplesChecked, j;

  pics_event_source pics_event_source_i (.evReq(evReq), .linkClk(linkClk), .evLine(evLine));
  pics_interrupt_control pics_interrupt_control_i (
    .mclk(mclk), .arst_n(arst_n), .avs_address(avsAddr), .avs_read(avsRead), .avs_write(avsWrite),
    .avs_writedata(avsWdata), .avs_byteenable(avsBe), .avs_readdata(avsRdata),
    .avs_waitrequest(avsWait), .linkClk(linkClk), .evJabber(evLine[7]), .evRxError(evLine[6]),
    .evPageRx(evLine[5]), .evParDetFault(evLine[4]), .evLpAck(evLine[3]), .evLinkDown(evLine[2]),
    .evRemoteFault(evLine[1]), .evLinkUp(evLine[0]), .irq(irq));

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      failCount++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic busXfer(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
    avsAddr  <= a;
    avsWdata <= d;
    avsBe    <= be;
    avsRead  <= !wr;
    avsWrite <= wr;
    do @(posedge mclk); while (avsWait !== 1'b0);
    rd = avsRdata;
    avsRead  <= 1'b0;
    avsWrite <= 1'b0;
    @(posedge mclk);
  endtask : busXfer

  task automatic pulse(input int k);
    evReq <= 8'h01 << k;
    repeat (16) @(posedge mclk);
    evReq <= 8'h00;
    repeat (40) @(posedge mclk);
  endtask : pulse

  task automatic finishTest();
    $display("Checks %0d, errors %0d", samplesChecked, failCount);
    if (failCount == 0 && samplesChecked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : finishTest

  initial begin
    #2000000;
    failCount++;
    finishTest();
  end

  initial begin
    {avsRead, avsWrite, arst_n} = 3'h0;
    {avsAddr, evReq, avsWdata, avsBe} = '0;
    repeat (3) @(posedge mclk);
    arst_n <= 1'b1;
    @(posedge mclk);
    busXfer(1'b0, PICS_REG_ADDR, 32'h0, 4'hF);
    chk(rd, 32'h0000_0000);
    chk({31'h0, irq}, 32'h0);
    busXfer(1'b1, PICS_REG_ADDR, 32'hFFFF_FFFF, 4'hF);
    busXfer(1'b0, PICS_REG_ADDR, 32'h0, 4'hF);
    chk(rd, 32'h0000_FF00);
    busXfer(1'b1, PICS_REG_ADDR, 32'h0000_5A00, 4'hD);
    busXfer(1'b1, 8'h70, 32'h0000_0000, 4'hF);
    busXfer(1'b0, 8'h70, 32'h0, 4'hF);
    chk(rd, 32'h0000_0000);
    busXfer(1'b0, PICS_REG_ADDR, 32'h0, 4'hF);
    chk(rd, 32'h0000_FF00);
    for (int i = 0; i < 8; i++) begin
      j  = (i + 1) % 8;
      en = 16'h0100 << i;
      busXfer(1'b1, PICS_REG_ADDR, {16'h0, en}, 4'hF);
      pulse(j);
      chk({31'h0, irq}, 32'h0);
      pulse(i);
      chk({31'h0, irq}, 32'h1);
      busXfer(1'b0, PICS_REG_ADDR, 32'h0, 4'hF);
      chk(rd, {16'h0, en | (16'h1 << i) | (16'h1 << j)});
      repeat (3) @(posedge mclk);
      chk({31'h0, irq}, 32'h0);
      busXfer(1'b0, PICS_REG_ADDR, 32'h0, 4'hF);
      chk(rd, {16'h0, en});
    end
    evReq <= 8'h01;
    repeat (8) busXfer(1'b0, PICS_REG_ADDR, 32'h0, 4'hF);
    repeat (40) @(posedge mclk);
    busXfer(1'b0, PICS_REG_ADDR, 32'h0, 4'hF);
    chk(rd, 32'h0000_8001);
    evReq <= 8'h00;
    repeat (40) @(posedge mclk);
    busXfer(1'b0, PICS_REG_ADDR, 32'h0, 4'hF);
    busXfer(1'b0, PICS_REG_ADDR, 32'h0, 4'hF);
    chk(rd, 32'h0000_8000);
    finishTest();
  end
endmodule : testbench
`default_nettype wire
